// File: core/dbsd_regs.vh
`ifndef DBSD_REGS_VH
`define DBSD_REGS_VH

// Clock and timing, in nanoseconds
`define DBSD_CLK_PERIOD_NS 50
`define DBSD_START_BUS_NS 50
`define DBSD_START_REF_NS 150
`define DBSD_ROW_HOLD_NS 100
`define DBSD_COL_SETUP_NS 50
`define DBSD_CAS_NS 150
`define DBSD_PRECHARGE_NS 150
`define DBSD_REFRESH_PERIOD_NS 25000

// Least time rounds up, longest time rounds down
`define DBSD_CYC_MIN(ns) (((ns) + `DBSD_CLK_PERIOD_NS - 1) / `DBSD_CLK_PERIOD_NS)
`define DBSD_CYC_MAX(ns) ((ns) / `DBSD_CLK_PERIOD_NS)

// Register byte offsets
`define DBSD_REG_CONTROL 8'h00
`define DBSD_REG_STATUS 8'h04
`define DBSD_REG_REFRESH_TOTAL 8'h08

// Control fields
`define DBSD_CTRL_ENABLE_BIT 0
`define DBSD_CTRL_BASE_LSB 4
`define DBSD_CTRL_BASE_MSB 8
`define DBSD_CTRL_RESET 32'h00000001

// Status fields
`define DBSD_STAT_ROW_LSB 0
`define DBSD_STAT_ROW_MSB 5
`define DBSD_STAT_PEND_BIT 8
`define DBSD_STAT_BUSY_BIT 9
`define DBSD_STAT_CODE_LSB 12
`define DBSD_STAT_CODE_MSB 13

// Transfer codes, high bit first
`define DBSD_XFER_WORD_READ 2'h3
`define DBSD_XFER_READ_PAUSE 2'h2
`define DBSD_XFER_WORD_WRITE 2'h1
`define DBSD_XFER_BYTE_WRITE 2'h0

// AXI responses
`define DBSD_RESP_OKAY 2'h0
`define DBSD_RESP_DECERR 2'h3

`endif

// File: core/dbsd_core.v
// What this block does
// - Decode 4K block hit, use word bits 12:1
// - Address latches transparent until strobe, then hold
// - Chip lines idle high; bus bits 12:7 loaded as row at address strobe
// - Address strobe freezes address, drives chip lines
// - Column select drives latched bits 6:1
// - One refresh cycle every 25 us, 64 rows
// - Refresh routes row counter, row strobe only
// - Control bits pick read, pause, write, byte
// - Read-with-pause handled as plain word read
// - Word write: latch early, both byte strobes later
// - Byte write picks upper or lower by bit 0
// - Upper strobe feeds upper byte and parity chips
// - Bus access strobes only the selected bank; refresh strobes all banks
// - Write data held, stored with byte and column strobe
// - Sync flag after latch strobe, own driver replies
// - Read loads chip output, drive enable puts on bus
// - Address present at latches before timing starts
// - Every addressed access answered with slave reply, unless parity_present_n is low
// - Row counter advances when column select falls
// - Pending refresh waits for bus cycle to end
`timescale 1ns/100ps
`include "dbsd_regs.vh"

module dbsd_core #(
   parameter BANKS = 4,
   parameter AXI_ADDR_W = 8
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite register slave
   input wire [AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [AXI_ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // System bus, active-low lines except data, output enables and sync flag
   input wire [17:13] bus_block_addr_n,
   input wire [12:1] bus_word_address_n,
   input wire byte_select_addr_n,
   input wire transfer_code_hi_n,
   input wire transfer_code_lo_n,
   input wire bus_master_sync_n,
   input wire [15:0] bus_data_in,
   output wire [15:0] bus_data_out,
   output wire bus_data_oe,
   output wire bus_slave_reply_out,
   output wire bus_slave_reply_oe,
   input wire parity_present_n,
   output wire internal_slave_sync_n,
   output wire slave_sync_flag,
   // Memory array
   output wire [5:0] chip_address_lines,
   output wire [BANKS-1:0] bank_row_strobe_n,
   output wire column_strobe_n,
   output wire upper_byte_write_n,
   output wire lower_byte_write_n,
   output wire [15:0] chip_data_out,
   input wire [15:0] chip_data_in,
   // Timing chain observation
   output wire cycle_start,
   output wire address_strobe,
   output wire column_select,
   output wire refresh_active,
   output wire data_latch_strobe,
   output wire bus_drive_enable,
   output wire [5:0] refresh_row_count
);

   localparam ST_IDLE = 3'h0;
   localparam ST_START = 3'h1;
   localparam ST_ROW = 3'h2;
   localparam ST_COL = 3'h3;
   localparam ST_CAS = 3'h4;
   localparam ST_REPLY = 3'h5;
   localparam ST_PRECH = 3'h6;

   localparam integer CYC_START_BUS = `DBSD_CYC_MIN(`DBSD_START_BUS_NS);
   localparam integer CYC_START_REF = `DBSD_CYC_MIN(`DBSD_START_REF_NS);
   localparam integer CYC_ROW = `DBSD_CYC_MIN(`DBSD_ROW_HOLD_NS);
   localparam integer CYC_COL = `DBSD_CYC_MIN(`DBSD_COL_SETUP_NS);
   localparam integer CYC_CAS = `DBSD_CYC_MIN(`DBSD_CAS_NS);
   localparam integer CYC_PRECH = `DBSD_CYC_MIN(`DBSD_PRECHARGE_NS);
   localparam integer CYC_REFRESH = `DBSD_CYC_MAX(`DBSD_REFRESH_PERIOD_NS);
   localparam [BANKS-1:0] ALL_BANKS = {BANKS{1'b1}};

   // Block offset from base; hit if inside the installed banks
   function [5:0] block_offset;
      input [4:0] blk;
      input [4:0] base;
      begin
         block_offset = {1'b0, blk} - {1'b0, base};
      end
   endfunction

   function [3:0] dly_load;
      input integer cyc;
      begin
         dly_load = cyc[3:0] - 4'h1;
      end
   endfunction

   reg [2:0] state_ff;
   reg [3:0] dly_ff;
   reg cycle_start_ff, address_strobe_ff, column_select_ff, refresh_active_ff;
   reg data_latch_strobe_ff, bus_drive_enable_ff, slave_sync_flag_ff;
   reg reply_oe_ff;
   reg [5:0] chip_addr_ff;
   reg [BANKS-1:0] row_strobe_n_ff;
   reg column_strobe_n_ff, upper_wr_n_ff, lower_wr_n_ff;
   reg [15:0] hold_ff;
   reg [12:1] latched_word_address_ff;
   reg [1:0] latched_code_ff;
   reg latched_byte_ff;
   reg [5:0] refresh_row_count_ff;
   reg [9:0] ref_timer_ff;
   reg ref_pend_ff;
   reg [15:0] refresh_total_ff;
   reg [31:0] ctrl_ff;
   reg [1:0] last_code_ff;

   wire [4:0] bus_block = ~bus_block_addr_n;
   wire [12:1] bus_word = ~bus_word_address_n;
   wire [1:0] bus_code = {~transfer_code_hi_n, ~transfer_code_lo_n};
   wire bus_byte = ~byte_select_addr_n;
   wire [5:0] blk_off = block_offset(bus_block, ctrl_ff[`DBSD_CTRL_BASE_MSB:`DBSD_CTRL_BASE_LSB]);
   wire [1:0] bank_sel = blk_off[1:0];
   // hit only when enabled and inside an installed 4K block
   wire addr_hit = ctrl_ff[`DBSD_CTRL_ENABLE_BIT] && (blk_off < BANKS);
   // a bus request wins over a waiting refresh
   wire bus_req = !bus_master_sync_n && addr_hit;
   // high code bit set means a read of either kind
   wire bus_is_read = bus_code[1];
   wire [BANKS-1:0] bank_onehot = ALL_BANKS & ({{(BANKS-1){1'b0}}, 1'b1} << bank_sel);

   // transparent while the strobe is low, holds from its rise
   always @(posedge aclk) begin
      if (!aresetn) begin
         latched_word_address_ff <= 12'h000;
         latched_code_ff <= 2'h0;
         latched_byte_ff <= 1'b0;
      end else if (!address_strobe_ff) begin
         latched_word_address_ff <= bus_word;
         latched_code_ff <= bus_code;
         latched_byte_ff <= bus_byte;
      end
   end

   // refresh interval timer, restarted as column select falls
   always @(posedge aclk) begin
      if (!aresetn) begin
         ref_timer_ff <= 10'h000;
         ref_pend_ff <= 1'b0;
      end else if (state_ff == ST_COL && refresh_active_ff && dly_ff == 4'h0) begin
         ref_timer_ff <= 10'h000;
         ref_pend_ff <= 1'b0;
      end else if (!ref_pend_ff) begin
         if (ref_timer_ff == CYC_REFRESH[9:0] - 10'h001) begin
            ref_pend_ff <= 1'b1;
            ref_timer_ff <= 10'h000;
         end else begin
            ref_timer_ff <= ref_timer_ff + 10'h001;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ST_IDLE;
         dly_ff <= 4'h0;
         cycle_start_ff <= 1'b0;
         address_strobe_ff <= 1'b0;
         column_select_ff <= 1'b0;
         refresh_active_ff <= 1'b0;
         data_latch_strobe_ff <= 1'b0;
         bus_drive_enable_ff <= 1'b0;
         slave_sync_flag_ff <= 1'b0;
         reply_oe_ff <= 1'b0;
         chip_addr_ff <= 6'h3F;
         row_strobe_n_ff <= ALL_BANKS;
         column_strobe_n_ff <= 1'b1;
         upper_wr_n_ff <= 1'b1;
         lower_wr_n_ff <= 1'b1;
         hold_ff <= 16'h0000;
         refresh_row_count_ff <= 6'h00;
         refresh_total_ff <= 16'h0000;
         last_code_ff <= 2'h0;
      end else begin
         data_latch_strobe_ff <= 1'b0;
         if (dly_ff != 4'h0) begin
            dly_ff <= dly_ff - 4'h1;
         end
         case (state_ff)
            ST_IDLE: begin
               if (bus_req) begin
                  state_ff <= ST_START;
                  dly_ff <= dly_load(CYC_START_BUS);
                  cycle_start_ff <= 1'b1;
                  last_code_ff <= bus_code;
                  if (bus_is_read) begin
                     bus_drive_enable_ff <= 1'b1;
                  end else begin
                     data_latch_strobe_ff <= 1'b1;
                     hold_ff <= bus_data_in;
                  end
               end else if (ref_pend_ff) begin
                  // Longer start gives the row mux time to settle
                  state_ff <= ST_START;
                  dly_ff <= dly_load(CYC_START_REF);
                  cycle_start_ff <= 1'b1;
                  refresh_active_ff <= 1'b1;
               end
            end
            ST_START: begin
               if (dly_ff == 4'h0) begin
                  state_ff <= ST_ROW;
                  dly_ff <= dly_load(CYC_ROW);
                  address_strobe_ff <= 1'b1;
                  if (refresh_active_ff) begin
                     chip_addr_ff <= refresh_row_count_ff;
                     row_strobe_n_ff <= ~ALL_BANKS;
                  end else begin
                     chip_addr_ff <= bus_word[12:7];
                     row_strobe_n_ff <= ~bank_onehot;
                  end
               end
            end
            ST_ROW: begin
               if (dly_ff == 4'h0) begin
                  state_ff <= ST_COL;
                  dly_ff <= dly_load(CYC_COL);
                  column_select_ff <= 1'b1;
                  // Refresh mux outputs ground, so chip lines idle high
                  chip_addr_ff <= refresh_active_ff ? 6'h3F : latched_word_address_ff[6:1];
               end
            end
            ST_COL: begin
               if (dly_ff == 4'h0) begin
                  if (refresh_active_ff) begin
                     // No column strobe: the whole row refreshes
                     state_ff <= ST_PRECH;
                     dly_ff <= dly_load(CYC_PRECH);
                     column_select_ff <= 1'b0;
                     address_strobe_ff <= 1'b0;
                     row_strobe_n_ff <= ALL_BANKS;
                     chip_addr_ff <= 6'h3F;
                     refresh_row_count_ff <= refresh_row_count_ff + 6'h01;
                     refresh_total_ff <= refresh_total_ff + 16'h0001;
                  end else begin
                     state_ff <= ST_CAS;
                     dly_ff <= dly_load(CYC_CAS);
                     column_strobe_n_ff <= 1'b0;
                     case (latched_code_ff)
                        `DBSD_XFER_WORD_WRITE: begin
                           upper_wr_n_ff <= 1'b0;
                           lower_wr_n_ff <= 1'b0;
                        end
                        `DBSD_XFER_BYTE_WRITE: begin
                           upper_wr_n_ff <= ~latched_byte_ff;
                           lower_wr_n_ff <= latched_byte_ff;
                        end
                        default: begin
                           upper_wr_n_ff <= 1'b1;
                           lower_wr_n_ff <= 1'b1;
                        end
                     endcase
                  end
               end
            end
            ST_CAS: begin
               if (dly_ff == 4'h0) begin
                  state_ff <= ST_REPLY;
                  upper_wr_n_ff <= 1'b1;
                  lower_wr_n_ff <= 1'b1;
                  if (latched_code_ff[1]) begin
                     data_latch_strobe_ff <= 1'b1;
                     hold_ff <= chip_data_in;
                  end
               end
            end
            ST_REPLY: begin
               if (!slave_sync_flag_ff) begin
                  // One cycle after the read latch strobe; writes latched at cycle start
                  slave_sync_flag_ff <= 1'b1;
                  reply_oe_ff <= parity_present_n;
               end else if (bus_master_sync_n) begin
                  state_ff <= ST_PRECH;
                  dly_ff <= dly_load(CYC_PRECH);
                  slave_sync_flag_ff <= 1'b0;
                  reply_oe_ff <= 1'b0;
                  bus_drive_enable_ff <= 1'b0;
                  address_strobe_ff <= 1'b0;
                  column_select_ff <= 1'b0;
                  column_strobe_n_ff <= 1'b1;
                  row_strobe_n_ff <= ALL_BANKS;
                  chip_addr_ff <= 6'h3F;
               end
            end
            ST_PRECH: begin
               cycle_start_ff <= 1'b0;
               if (dly_ff == 4'h0) begin
                  state_ff <= ST_IDLE;
                  refresh_active_ff <= 1'b0;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // AXI4-Lite slave: one write and one read in flight
   reg awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   reg aw_held_ff, w_held_ff;
   reg [AXI_ADDR_W-1:0] awaddr_ff;
   reg [31:0] wdata_ff, rdata_ff;
   reg [3:0] wstrb_ff;
   reg [1:0] bresp_ff, rresp_ff;
   reg [31:0] nxt_ctrl;
   reg [31:0] rd_word;
   reg rd_ok;
   integer i;

   wire aw_take = s_axi_awvalid && awready_ff;
   wire w_take = s_axi_wvalid && wready_ff;
   wire wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
   wire [31:0] status_word = {18'h00000, last_code_ff, 2'h0,
      (state_ff != ST_IDLE), ref_pend_ff, 2'h0, refresh_row_count_ff};

   always @* begin
      nxt_ctrl = ctrl_ff;
      for (i = 0; i < 4; i = i + 1) begin
         if (wstrb_ff[i]) begin
            nxt_ctrl[i*8 +: 8] = wdata_ff[i*8 +: 8];
         end
      end
      nxt_ctrl[31:9] = 23'h000000;
      nxt_ctrl[3:1] = 3'h0;
   end

   always @* begin
      rd_word = 32'h00000000;
      rd_ok = 1'b1;
      case (s_axi_araddr[7:0] & 8'hFC)
         `DBSD_REG_CONTROL: rd_word = ctrl_ff;
         `DBSD_REG_STATUS: rd_word = status_word;
         `DBSD_REG_REFRESH_TOTAL: rd_word = {16'h0000, refresh_total_ff};
         default: rd_ok = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         awaddr_ff <= {AXI_ADDR_W{1'b0}};
         wdata_ff <= 32'h00000000;
         wstrb_ff <= 4'h0;
         bresp_ff <= `DBSD_RESP_OKAY;
         rresp_ff <= `DBSD_RESP_OKAY;
         rdata_ff <= 32'h00000000;
         ctrl_ff <= `DBSD_CTRL_RESET;
      end else begin
         awready_ff <= !aw_held_ff && !aw_take;
         wready_ff <= !w_held_ff && !w_take;
         if (aw_take) begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_go) begin
            bvalid_ff <= 1'b1;
            case (awaddr_ff[7:0] & 8'hFC)
               `DBSD_REG_CONTROL: begin
                  ctrl_ff <= nxt_ctrl;
                  bresp_ff <= `DBSD_RESP_OKAY;
               end
               `DBSD_REG_STATUS, `DBSD_REG_REFRESH_TOTAL: bresp_ff <= `DBSD_RESP_OKAY;
               default: bresp_ff <= `DBSD_RESP_DECERR;
            endcase
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
         end
         arready_ff <= !rvalid_ff && !(s_axi_arvalid && arready_ff);
         if (s_axi_arvalid && arready_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_ok ? `DBSD_RESP_OKAY : `DBSD_RESP_DECERR;
         end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   assign bus_data_out = hold_ff;
   assign bus_data_oe = bus_drive_enable_ff;
   // Open drain: the line is only ever pulled low
   assign bus_slave_reply_out = 1'b0;
   assign bus_slave_reply_oe = reply_oe_ff;
   assign internal_slave_sync_n = ~slave_sync_flag_ff;
   assign slave_sync_flag = slave_sync_flag_ff;
   assign chip_address_lines = chip_addr_ff;
   assign bank_row_strobe_n = row_strobe_n_ff;
   assign column_strobe_n = column_strobe_n_ff;
   assign upper_byte_write_n = upper_wr_n_ff;
   assign lower_byte_write_n = lower_wr_n_ff;
   assign chip_data_out = hold_ff;
   assign cycle_start = cycle_start_ff;
   assign address_strobe = address_strobe_ff;
   assign column_select = column_select_ff;
   assign refresh_active = refresh_active_ff;
   assign data_latch_strobe = data_latch_strobe_ff;
   assign bus_drive_enable = bus_drive_enable_ff;
   assign refresh_row_count = refresh_row_count_ff;

endmodule

// File: dv/dbsd_bus_master.sv
`timescale 1ns/100ps
module dbsd_bus_master (
   // Clock and command
   input wire aclk,
   input wire req,
   input wire [1:0] code,
   input wire [4:0] blk,
   input wire [11:0] addr,
   input wire bsel,
   input wire [15:0] wdata,
   input wire reply_n,
   output reg busy,
   // Bus lines, active low except data
   output reg [17:13] block_n,
   output reg [12:1] word_n,
   output reg bsel_n,
   output reg code_hi_n,
   output reg code_lo_n,
   output wire msync_n,
   output reg [15:0] data
);
   assign msync_n = !busy;
   initial begin
      busy = 0;
      {block_n, word_n, bsel_n, code_hi_n, code_lo_n, data} = 36'hF_FFFF_0000;
   end
   always @(posedge aclk) begin
      if (!busy && req && reply_n) begin
         busy <= 1;
         {block_n, word_n, bsel_n, code_hi_n, code_lo_n, data} <= {~blk, ~addr, ~bsel, ~code, wdata};
      end else if (busy && (!reply_n || !req)) begin
         // Hold until the reply or until req drops, then flip released lines so stale samples show
         busy <= 0;
         {block_n, word_n, bsel_n, code_hi_n, code_lo_n, data} <= ~{block_n, word_n, bsel_n, code_hi_n, code_lo_n, data};
      end
   end
endmodule

// File: dv/dbsd_core_properties.sv
`timescale 1ns/100ps
module dbsd_core_properties #(
   parameter BANKS = 4
) (
   // Clock and reset
   input logic aclk,
   input logic aresetn,
   // Bus side
   input logic [12:1] bus_word_address_n,
   input logic byte_select_addr_n,
   input logic transfer_code_hi_n,
   input logic transfer_code_lo_n,
   input logic parity_present_n,
   input logic bus_slave_reply_oe,
   input logic slave_sync_flag,
   // Array side
   input logic [5:0] chip_address_lines,
   input logic [BANKS-1:0] bank_row_strobe_n,
   input logic column_strobe_n,
   input logic upper_byte_write_n,
   input logic lower_byte_write_n,
   // Timing chain
   input logic cycle_start,
   input logic address_strobe,
   input logic column_select,
   input logic refresh_active,
   input logic data_latch_strobe,
   input logic bus_drive_enable,
   input logic [5:0] refresh_row_count
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_row_addr: assert property ($rose(address_strobe) && !refresh_active
      |-> chip_address_lines == ~bus_word_address_n[12:7]) else $error("row address wrong");
   a_col_addr: assert property ($rose(column_select) && !refresh_active
      |-> chip_address_lines == ~bus_word_address_n[6:1]) else $error("column address wrong");
   a_ref_lines: assert property ($rose(address_strobe) && refresh_active
      |-> chip_address_lines == refresh_row_count) else $error("refresh row not on lines");
   a_row_advance: assert property ($fell(column_select) && $past(refresh_active)
      |-> refresh_row_count == $past(refresh_row_count) + 6'h01) else $error("row count not advanced");
   a_word_strobes: assert property ($fell(column_strobe_n) && !refresh_active && transfer_code_hi_n
      && !transfer_code_lo_n |-> !upper_byte_write_n && !lower_byte_write_n) else $error("word write strobes");
   a_byte_strobe: assert property ($fell(column_strobe_n) && !refresh_active && transfer_code_hi_n
      && transfer_code_lo_n |-> upper_byte_write_n == byte_select_addr_n && lower_byte_write_n == !byte_select_addr_n)
      else $error("byte write strobe wrong");
   a_read_quiet: assert property (bus_drive_enable
      |-> upper_byte_write_n && lower_byte_write_n && !refresh_active) else $error("write strobe during read");
   a_reply_time: assert property ($rose(cycle_start) && !refresh_active
      |-> ##[7:8] slave_sync_flag) else $error("no slave reply in time");
   a_reply_drive: assert property (bus_slave_reply_oe == (slave_sync_flag && parity_present_n))
      else $error("reply driver wrong");
   a_latch_sync: assert property (data_latch_strobe && bus_drive_enable |=> slave_sync_flag)
      else $error("sync not after read latch");
   a_banks_idle: assert property (!cycle_start |-> &bank_row_strobe_n)
      else $error("row strobe outside cycle");
endmodule
bind dbsd_core dbsd_core_properties #(.BANKS(BANKS)) u_props (.*);

// File: dv/dbsd_core_bench.sv
`timescale 1ns/100ps
`include "dbsd_regs.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module dbsd_core_bench;
   logic aclk = 0;
   logic aresetn = 0;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, parity_present_n;
   logic [15:0] chip_data_in, m_data;
   logic req, m_bsel, wu, wl, s_oe, s_rep;
   logic [1:0] m_code;
   logic [4:0] m_blk;
   logic [11:0] m_addr;
   logic [3:0] bk;
   logic [5:0] r;
   int bad_count = 0;
   int n_tests = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, m_busy;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [17:13] bus_block_addr_n;
   wire [12:1] bus_word_address_n;
   wire byte_select_addr_n, transfer_code_hi_n, transfer_code_lo_n, bus_master_sync_n;
   wire [15:0] bus_data_in, bus_data_out, chip_data_out;
   wire bus_data_oe, bus_slave_reply_oe, internal_slave_sync_n, slave_sync_flag, column_strobe_n;
   wire upper_byte_write_n, lower_byte_write_n, refresh_active;
   wire [3:0] bank_row_strobe_n;
   wire [5:0] refresh_row_count;
   dbsd_core #(.BANKS(4), .AXI_ADDR_W(8)) uut (.*, .bus_slave_reply_out(), .chip_address_lines(),
      .cycle_start(), .address_strobe(), .column_select(), .data_latch_strobe(), .bus_drive_enable());
   dbsd_bus_master master (.aclk(aclk), .req(req), .code(m_code), .blk(m_blk), .addr(m_addr),
      .bsel(m_bsel), .wdata(m_data), .reply_n(internal_slave_sync_n), .busy(m_busy),
      .block_n(bus_block_addr_n), .word_n(bus_word_address_n), .bsel_n(byte_select_addr_n),
      .code_hi_n(transfer_code_hi_n), .code_lo_n(transfer_code_lo_n), .msync_n(bus_master_sync_n),
      .data(bus_data_in));
   always #25 aclk = ~aclk;
   // Sticky capture of what each bus cycle did, refresh traffic ignored
   always @(posedge aclk) begin
      if (!refresh_active && !upper_byte_write_n) wu <= 0;
      if (!refresh_active && !lower_byte_write_n) wl <= 0;
      if (!refresh_active && !(&bank_row_strobe_n)) bk <= bk & bank_row_strobe_n;
      if (slave_sync_flag) s_oe <= bus_data_oe;
      if (slave_sync_flag) s_rep <= bus_slave_reply_oe;
   end
   task automatic axi_wr(input [7:0] a, input [31:0] d, input [1:0] er);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1;
         s_axi_wvalid <= 1;
         s_axi_bready <= 1;
         do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
         end while (!s_axi_bvalid);
         s_axi_bready <= 0;
         `CHK(s_axi_bresp, er)
         @(posedge aclk);
      end
   endtask
   task automatic axi_rd(input [7:0] a, input [31:0] ed, input [1:0] er);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1;
         s_axi_rready <= 1;
         do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
         end while (!s_axi_rvalid);
         s_axi_rready <= 0;
         `CHK({s_axi_rresp, s_axi_rdata}, {er, ed})
         @(posedge aclk);
      end
   endtask
   task automatic bus_op(input [1:0] c, input [4:0] b, input [11:0] a, input s, input [15:0] d, input hit);
      int i;
      begin
         wu = 1;
         wl = 1;
         bk = 4'hF;
         {m_code, m_blk, m_addr, m_bsel, m_data} <= {c, b, a, s, d};
         req <= 1;
         repeat (2) @(posedge aclk);
         for (i = 0; i < 60 && m_busy; i++) @(posedge aclk);
         req <= 0;
         repeat (3) @(posedge aclk);
         `CHK(i < 60, hit)
      end
   endtask
   task automatic t_write;
      int s;
      begin
         bus_op(`DBSD_XFER_WORD_WRITE, 5'h00, 12'hA5C, 0, 16'hC35A, 1);
         `CHK({wu, wl, bk}, 6'h0E)
         `CHK(chip_data_out, 16'hC35A)
         for (s = 0; s < 2; s++) begin
            bus_op(`DBSD_XFER_BYTE_WRITE, 5'h01, 12'h3C1, s[0], 16'h1234, 1);
            `CHK({wu, wl, bk}, {!s[0], s[0], 4'hD})
         end
      end
   endtask
   task automatic t_read;
      int c;
      begin
         for (c = 2; c < 4; c++) begin
            chip_data_in <= 16'h8E71 ^ c[15:0];
            bus_op(c[1:0], 5'h02, 12'hF0F, 0, 16'h0000, 1);
            `CHK(bus_data_out, 16'h8E71 ^ c[15:0])
            `CHK({s_oe, s_rep, wu, wl, bk}, 8'hFB)
         end
         parity_present_n <= 0;
         bus_op(`DBSD_XFER_WORD_READ, 5'h03, 12'h001, 0, 16'h0000, 1);
         `CHK({s_rep, bk}, 5'h07)
         parity_present_n <= 1;
      end
   endtask
   task automatic t_select;
      begin
         bus_op(`DBSD_XFER_WORD_READ, 5'h05, 12'h123, 0, 16'h0000, 0);
         axi_wr(`DBSD_REG_CONTROL, 32'h0000_0000, `DBSD_RESP_OKAY);
         bus_op(`DBSD_XFER_WORD_READ, 5'h00, 12'h123, 0, 16'h0000, 0);
         axi_wr(`DBSD_REG_CONTROL, 32'h0000_0031, `DBSD_RESP_OKAY);
         axi_rd(`DBSD_REG_CONTROL, 32'h0000_0031, `DBSD_RESP_OKAY);
         bus_op(`DBSD_XFER_WORD_WRITE, 5'h04, 12'h0FF, 0, 16'hFFFF, 1);
         `CHK(bk, 4'hD)
      end
   endtask
   task automatic t_refresh;
      int i;
      begin
         for (i = 0; i < 700 && !refresh_active; i++) @(posedge aclk);
         r = refresh_row_count;
         // Bus request lands mid refresh and must wait for it
         bus_op(`DBSD_XFER_WORD_READ, 5'h04, 12'h555, 0, 16'h0000, 1);
         `CHK(refresh_row_count, r + 6'h01)
         // Row step of the next refresh to the start of the one after: 25 us
         for (i = 0; i < 700 && refresh_row_count == r + 6'h01; i++) @(posedge aclk);
         for (i = 0; i < 700 && !(refresh_active && i > 20); i++) @(posedge aclk);
         `CHK(i > 495 && i < 505, 1'b1)
      end
   endtask
   task end_sim;
      begin
         if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, chip_data_in, req} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_wstrb, parity_present_n, s_oe, s_rep} = 7'h7F;
      {m_code, m_blk, m_addr, m_bsel, m_data} = '0;
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      repeat (3) @(posedge aclk);
      axi_rd(`DBSD_REG_CONTROL, `DBSD_CTRL_RESET, `DBSD_RESP_OKAY);
      axi_rd(8'h40, 32'h0000_0000, `DBSD_RESP_DECERR);
      axi_wr(8'h40, 32'hFFFF_FFFF, `DBSD_RESP_DECERR);
      t_write;
      t_read;
      t_select;
      t_refresh;
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      end_sim;
   end
endmodule
